/* core/lsl_top.sv */
// serial shift register, output latch, gate, fault capture and watchdog
//
// Summary of operation
// - sixteen-bit shift register fed by serial data
// - data leaves serial output sixteen clocks later
// - load strobe copies shift register into latch
// - active-low gate switches all sinks together
// - each driven output watched for an open LED
// - strobe rise loads fault status for shifting
// - faults shift out during the next transfer
// - idle past watchdog period clears the latch
// - watchdog clear leaves shift register alone
// - outputs stay off until the next load
// - input sampled on serial clock rising edge
// - output stage updates on serial clock rise
// - latch transparent while strobe high, holds low
// - gate high releases sinks, latch untouched
`timescale 1ns/1ps
module lsl_top #(
   parameter int WDOG_CYCLES = lsl_pkg::WDOG_CYCLES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   output logic serial_data_o,
   input wire logic latch_load_strobe_i,
   input wire logic output_gate_n_i,
   input wire logic [15:0] led_open_i,
   output logic [15:0] led_sink_lines_o,
   output logic [15:0] led_sink_lines_oe_o
);

   // ************************************************************
   // declarations
   // ************************************************************
   localparam int W = lsl_pkg::SR_W;

   logic [W-1:0] sr_r;
   logic [W-1:0] sr_nxt;
   logic dout_r;
   logic dout_nxt;
   logic seen_tog_r;
   logic load_now;

   logic [2:0] ctl_s;
   logic sclk_s;
   logic strobe_s;
   logic gate_n_s;
   logic [W-1:0] open_s;
   logic sclk_d_r;
   logic strobe_d_r;
   logic strobe_rise;
   logic activity;
   logic wd_clear;

   logic [W-1:0] latch_r;
   logic [W-1:0] fault_snap_r;
   logic load_tog_r;
   logic [W-1:0] sink_oe_r;

   generate
      if (W != 16) begin : g_bad_width
         $error("lsl_top: shift register must be sixteen bits");
      end
   endgenerate

   // sinks are driven only while the gate is low and the latch bit is set
   function automatic logic [15:0] sink_on(input logic [15:0] latch, input logic gate_n);
      sink_on = latch & {16{~gate_n}};
   endfunction : sink_on

   // ************************************************************
   // serial link domain
   // ************************************************************

   // a strobe rise seen in the core domain arms a one-shot fault load;
   // the toggle and snapshot settle long before the next serial edge
   assign load_now = (load_tog_r != seen_tog_r);

   always_comb begin
      if (load_now) begin
         sr_nxt = {fault_snap_r[W-2:0], serial_data_i};
         dout_nxt = fault_snap_r[W-1];
      end else begin
         sr_nxt = {sr_r[W-2:0], serial_data_i};
         dout_nxt = sr_r[W-1];
      end
   end

   always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sr_r <= lsl_pkg::SR_RST;
      end else begin
         sr_r <= sr_nxt;
      end
   end

   always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dout_r <= 1'b0;
      end else begin
         dout_r <= dout_nxt;
      end
   end

   always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seen_tog_r <= 1'b0;
      end else begin
         seen_tog_r <= load_tog_r;
      end
   end

   assign serial_data_o = dout_r;

   // ************************************************************
   // pin synchronisers into the core domain
   // ************************************************************
   // short gate path
   lsl_sync #(
      .W(3)
   ) u_sync_ctl (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i({serial_clk_i, latch_load_strobe_i, output_gate_n_i}),
      .q_o(ctl_s)
   );

   lsl_sync #(
      .W(W)
   ) u_sync_open (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i(led_open_i),
      .q_o(open_s)
   );

   assign sclk_s = ctl_s[2];
   assign strobe_s = ctl_s[1];
   assign gate_n_s = ctl_s[0];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strobe_d_r <= 1'b0;
      end else begin
         strobe_d_r <= strobe_s;
      end
   end

   assign strobe_rise = strobe_s && !strobe_d_r;

   // ************************************************************
   // watchdog
   // ************************************************************
   // transfers feed watchdog
   assign activity = (sclk_s != sclk_d_r) || (strobe_s != strobe_d_r);

   lsl_wdog #(
      .WDOG_CYCLES(WDOG_CYCLES)
   ) u_wdog (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .activity_i(activity),
      .expire_o(wd_clear)
   );

   // ************************************************************
   // output latch and fault capture
   // ************************************************************
   // transparent then hold
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latch_r <= lsl_pkg::LATCH_RST;
      end else if (wd_clear) begin
         latch_r <= lsl_pkg::LATCH_RST;
      end else if (strobe_s) begin
         latch_r <= sr_r;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_snap_r <= lsl_pkg::FAULT_RST;
      end else if (strobe_rise) begin
         fault_snap_r <= open_s & sink_on(latch_r, gate_n_s);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         load_tog_r <= 1'b0;
      end else if (strobe_rise) begin
         load_tog_r <= ~load_tog_r;
      end
   end

   // ************************************************************
   // sink drivers
   // ************************************************************
   // gate all together
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sink_oe_r <= 16'h0000;
      end else begin
         sink_oe_r <= sink_on(latch_r, gate_n_s);
      end
   end

   // open-drain: the pin is pulled low whenever it is enabled
   assign led_sink_lines_o = 16'h0000;
   assign led_sink_lines_oe_o = sink_oe_r;

   // ************************************************************
   // checks, serial domain
   // ************************************************************
   sequence s_plain_shift;
      !load_now;
   endsequence

   sequence s_fault_shift;
      load_now;
   endsequence

   property p_shift_in;
      @(posedge serial_clk_i) disable iff (!arst_n_i)
      s_plain_shift |=> (sr_r[0] == $past(serial_data_i)) && (sr_r[W-1:1] == $past(sr_r[W-2:0]));
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("shift register did not take the serial input");

   property p_dout_stage;
      @(posedge serial_clk_i) disable iff (!arst_n_i)
      s_plain_shift |=> serial_data_o == $past(sr_r[W-1]);
   endproperty
   a_dout_stage: assert property (p_dout_stage)
      else $error("serial output is not the last stage");

   property p_fault_load;
      @(posedge serial_clk_i) disable iff (!arst_n_i)
      s_fault_shift |=> (serial_data_o == $past(fault_snap_r[W-1]))
         && (sr_r[W-1:1] == $past(fault_snap_r[W-2:0])) && !load_now;
   endproperty
   a_fault_load: assert property (p_fault_load)
      else $error("fault word not loaded into the shift path");

   // ************************************************************
   // checks, core domain
   // ************************************************************
   sequence s_strobe_edge;
      !strobe_d_r && strobe_s;
   endsequence

   property p_latch_pass;
      @(posedge clk_i) disable iff (!arst_n_i)
      (strobe_s && !wd_clear) |=> latch_r == $past(sr_r);
   endproperty
   a_latch_pass: assert property (p_latch_pass)
      else $error("latch not transparent while strobe high");

   property p_latch_hold;
      @(posedge clk_i) disable iff (!arst_n_i)
      (!strobe_s && !wd_clear) |=> $stable(latch_r);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch changed while strobe low");

   property p_gate_off;
      @(posedge clk_i) disable iff (!arst_n_i)
      gate_n_s |=> (led_sink_lines_oe_o == 16'h0000)
         && ($stable(latch_r) || strobe_d_r || $past(wd_clear));
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("sinks driven while gate high");

   property p_sink_follow;
      @(posedge clk_i) disable iff (!arst_n_i)
      !gate_n_s |=> led_sink_lines_oe_o == $past(latch_r);
   endproperty
   a_sink_follow: assert property (p_sink_follow)
      else $error("sinks do not follow latch while gate low");

   property p_wd_clear;
      @(posedge clk_i) disable iff (!arst_n_i)
      wd_clear |=> (latch_r == 16'h0000) ##1 (led_sink_lines_oe_o == 16'h0000);
   endproperty
   a_wd_clear: assert property (p_wd_clear)
      else $error("watchdog expiry did not blank the outputs");

   property p_stay_off;
      @(posedge clk_i) disable iff (!arst_n_i)
      (latch_r == 16'h0000 && !strobe_s) |=> latch_r == 16'h0000;
   endproperty
   a_stay_off: assert property (p_stay_off)
      else $error("outputs came on without a load");

   property p_fault_capture;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_strobe_edge |=> (fault_snap_r == $past(open_s & sink_on(latch_r, gate_n_s)))
         && (load_tog_r != $past(load_tog_r));
   endproperty
   a_fault_capture: assert property (p_fault_capture)
      else $error("fault status not captured at strobe rise");

endmodule : lsl_top

/* core/lsl_pkg.sv */
// constants and types shared by the led shift-and-latch driver
package lsl_pkg;

   // ************************************************************
   // widths and reset values
   // ************************************************************
   localparam int SR_W = 16;
   localparam logic [15:0] SR_RST = 16'h0000;
   localparam logic [15:0] LATCH_RST = 16'h0000;
   localparam logic [15:0] FAULT_RST = 16'h0000;

   // ************************************************************
   // timing
   // ************************************************************
   localparam longint CLK_HZ = 100_000_000;
   localparam longint WDOG_NOM_MS = 1000;
   localparam longint WDOG_MIN_MS = 100;
   localparam longint WDOG_MAX_MS = 2500;
   // nominal period in cycles, rounded down as a longest time
   localparam int WDOG_CYCLES = int'((CLK_HZ * WDOG_NOM_MS) / 1000);
   localparam int WDOG_MIN_CYCLES = int'((CLK_HZ * WDOG_MIN_MS + 999) / 1000);
   localparam int WDOG_MAX_CYCLES = int'((CLK_HZ * WDOG_MAX_MS) / 1000);

   // ************************************************************
   // watchdog states
   // ************************************************************
   typedef enum logic [1:0] {
      WD_RUN = 2'b01,
      WD_TRIP = 2'b10
   } lsl_wd_state_type;

endpackage : lsl_pkg

/* core/lsl_sync.sv */
// two-flop level synchroniser for a bundle of independent bits
`timescale 1ns/1ps
module lsl_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   generate
      if (W < 1) begin : g_bad_width
         $error("lsl_sync: width must be at least one");
      end
   endgenerate

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= '0;
      end else begin
         meta_r <= d_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_r <= '0;
      end else begin
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;

endmodule : lsl_sync

/* core/lsl_wdog.sv */
// interface-idle watchdog: pulses a clear after a full idle period
`timescale 1ns/1ps
module lsl_wdog #(
   parameter int WDOG_CYCLES = lsl_pkg::WDOG_CYCLES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic activity_i,
   output logic expire_o
);

   localparam int CNT_W = $clog2(WDOG_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WDOG_CYCLES - 1);

   lsl_pkg::lsl_wd_state_type state_r;
   logic [CNT_W-1:0] cnt_r;

   generate
      if (WDOG_CYCLES < 2) begin : g_bad_period
         $error("lsl_wdog: period must be at least two cycles");
      end
   endgenerate

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= '0;
      end else if (activity_i || state_r == lsl_pkg::WD_TRIP) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= lsl_pkg::WD_RUN;
      end else begin
         case (state_r)
            lsl_pkg::WD_RUN: begin
               if (!activity_i && cnt_r == CNT_LAST) begin
                  state_r <= lsl_pkg::WD_TRIP;
               end
            end
            lsl_pkg::WD_TRIP: begin
               if (activity_i) begin
                  state_r <= lsl_pkg::WD_RUN;
               end
            end
            default: begin
               state_r <= lsl_pkg::WD_RUN;
            end
         endcase
      end
   end

   assign expire_o = (state_r == lsl_pkg::WD_RUN) && !activity_i && (cnt_r == CNT_LAST);

   property p_wd_restart;
      @(posedge clk_i) disable iff (!arst_n_i)
      activity_i |=> (cnt_r == '0) && !expire_o;
   endproperty
   a_wd_restart: assert property (p_wd_restart)
      else $error("watchdog did not restart on activity");

endmodule : lsl_wdog

/* verification/lsl_host_model.sv */
// host controller model: shifts words on the serial link and pulses the load strobe
`timescale 1ns/1ps
module lsl_host_model (
   output logic serial_clk_o,
   output logic serial_data_o,
   output logic strobe_o,
   input wire logic serial_data_i
);
   initial begin
      serial_clk_o = 1'b0;
      serial_data_o = 1'b0;
      strobe_o = 1'b0;
   end

   // ************************************************************
   // transfers
   // ************************************************************
   // msb first shifting
   task automatic shift(input logic [15:0] w, output logic [15:0] got);
      #37;
      for (int i = 15; i >= 0; i--) begin
         serial_data_o = w[i];
         #80 serial_clk_o = 1'b1;
         #80 serial_clk_o = 1'b0;
         got[i] = serial_data_i;
      end
      // clock stands still; the released data line shows the inverse level
      serial_data_o = ~serial_data_o;
   endtask : shift

   // strobe kept well clear of serial edges so the fault word settles
   task automatic load();
      #100 strobe_o = 1'b1;
      #100 strobe_o = 1'b0;
      #100;
   endtask : load
endmodule : lsl_host_model

/* verification/tb.sv */
// self-checking bench for the led shift-and-latch driver
`timescale 1ns/1ps
module tb;
   localparam int WD = 200;
   localparam logic [15:0] WA = 16'ha5c3;
   localparam logic [15:0] WB = 16'h1e87;
   localparam logic [15:0] WC = 16'h8001;
   localparam logic [15:0] WDD = 16'h7ffe;
   localparam logic [15:0] OPENS = 16'h0f0f;

   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic output_gate_n_i = 1'b0;
   logic [15:0] led_open_i = 16'h0000;
   logic serial_clk;
   logic serial_din;
   logic serial_dout;
   logic strobe;
   logic [15:0] oe;
   logic [15:0] sink_data;
   int fails = 0;
   int samples_checked = 0;

   always #5 clk_i = ~clk_i;

   lsl_host_model host_u (
      .serial_clk_o(serial_clk),
      .serial_data_o(serial_din),
      .strobe_o(strobe),
      .serial_data_i(serial_dout)
   );

   lsl_top #(.WDOG_CYCLES(WD)) dut_u (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .serial_clk_i(serial_clk),
      .serial_data_i(serial_din),
      .serial_data_o(serial_dout),
      .latch_load_strobe_i(strobe),
      .output_gate_n_i(output_gate_n_i),
      .led_open_i(led_open_i),
      .led_sink_lines_o(sink_data),
      .led_sink_lines_oe_o(oe)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic load_and_check(input logic [15:0] exp);
      host_u.load();
      cyc(8);
      chk("sink enables after load", exp, oe);
   endtask : load_and_check

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic s_reset();
      chk("sink enables in reset", 16'h0000, oe);
      chk("serial out in reset", 16'h0000, {15'h0000, serial_dout});
      chk("sink data level", 16'h0000, sink_data);
   endtask : s_reset

   task automatic s_load();
      logic [15:0] got;
      host_u.shift(WA, got);
      chk("shift out after reset", 16'h0000, got);
      load_and_check(WA);
      host_u.shift(WA, got);
      chk("fault word with no opens", 16'h0000, got);
      led_open_i = OPENS;
      cyc(3);
      load_and_check(WA);
   endtask : s_load

   task automatic s_gate();
      output_gate_n_i = 1'b1;
      cyc(5);
      chk("gate high releases sinks", 16'h0000, oe);
      output_gate_n_i = 1'b0;
      cyc(5);
      chk("gate low follows latch", WA, oe);
      chk("sink data low while enabled", 16'h0000, sink_data);
      for (int i = 0; i < 4; i++) begin
         output_gate_n_i = 1'b1;
         cyc(4);
         chk("pwm off phase", 16'h0000, oe);
         output_gate_n_i = 1'b0;
         cyc(4);
         chk("pwm on phase", WA, oe);
      end
   endtask : s_gate

   task automatic s_chain();
      logic [15:0] got;
      host_u.shift(WB, got);
      chk("fault word shifted out", WA & OPENS, got);
      host_u.shift(WC, got);
      chk("word out sixteen clocks later", WB, got);
      chk("latch kept during transfers", WA, oe);
   endtask : s_chain

   task automatic s_wdog();
      logic [15:0] got;
      cyc(WD - 50);
      chk("latch before watchdog period", WA, oe);
      cyc(80);
      chk("latch cleared by watchdog", 16'h0000, oe);
      led_open_i = 16'h0000;
      host_u.shift(WDD, got);
      chk("shift register kept by watchdog", WC, got);
      chk("outputs stay off until load", 16'h0000, oe);
      load_and_check(WDD);
   endtask : s_wdog

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      cyc(12);
      arst_n_i = 1'b1;
      cyc(3);
      s_reset();
      s_load();
      s_gate();
      s_chain();
      s_wdog();
      end_of_test();
   end

   initial begin
      #200000;
      fails++;
      $display("BAD run time limit expected finish seen hang");
      end_of_test();
   end
endmodule : tb
